// *** src/drive_status_pkg.sv ***
// Purpose: Shared constants and carriers for the drive status report block
// Assumes: One 200 MHz clock, asynchronous active high reset
// Notes: Parameter numbers are the drive's own parameter addresses
// Functional notes
// - Bit 0: drive can be enabled
// - Bit 1: master commands permit operation
// - Bit 2: drive enabled, accepts ramp release
// - Bit 3: drive in fault state
// - Bit 4: one unless coast stop disables
// - Bit 5: zero while quick stop active
// - Bit 7: at least one alarm active
// - Bit 9: drive controlled over fieldbus
// - Bit 6 carries no meaning
// - Read-only 16-bit word, resets to zero
// - Word sent only under drive profile
// - Module type: none, TCP, EIP, PNIO
// - Comm state is code zero to eight
// - Setup while awaiting config, then init
// - Wait comm, idle, data active codes
// - Communication error gives code five
// - Faults seven, eight persist until reinit or module absent
// - Profile from select; command only fieldbus
`default_nettype none
package drive_status_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned PNUM_W = 16;
   localparam int unsigned TYPE_W = 2;

   // Parameter numbers
   localparam logic [PNUM_W-1:0] PNUM_STATUS_WORD = 16'h03C8;
   localparam logic [PNUM_W-1:0] PNUM_COMMAND_WORD = 16'h03C7;
   localparam logic [PNUM_W-1:0] PNUM_MODULE_TYPE = 16'h0320;
   localparam logic [PNUM_W-1:0] PNUM_COMM_STATE = 16'h0321;
   localparam logic [PNUM_W-1:0] PNUM_PROFILE_SEL = 16'h02E5;

   // Status word bit positions
   localparam int unsigned SW_READY_ON = 0;
   localparam int unsigned SW_READY_OP = 1;
   localparam int unsigned SW_OP_EN = 2;
   localparam int unsigned SW_FAULT = 3;
   localparam int unsigned SW_NO_COAST = 4;
   localparam int unsigned SW_NO_QSTOP = 5;
   localparam int unsigned SW_ON_INHIBIT = 6;
   localparam int unsigned SW_WARNING = 7;
   localparam int unsigned SW_REMOTE = 9;

   // Command word bit positions
   localparam int unsigned CW_ON = 0;
   localparam int unsigned CW_NO_COAST = 1;
   localparam int unsigned CW_NO_QSTOP = 2;
   localparam int unsigned CW_EN_OP = 3;
   localparam int unsigned CW_EN_SETPOINT = 6;
   localparam int unsigned CW_FAULT_ACK = 7;

   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] COMMAND_RESET = 16'h0000;

   // Data profile selection code for the drive profile
   localparam logic [WORD_W-1:0] PROFILE_DRIVE = 16'h0001;

   // Module type codes
   localparam logic [TYPE_W-1:0] MOD_NONE = 2'h0;
   localparam logic [TYPE_W-1:0] MOD_MODBUS_TCP = 2'h1;
   localparam logic [TYPE_W-1:0] MOD_ETHERNET_IP = 2'h2;
   localparam logic [TYPE_W-1:0] MOD_PROFINET_IO = 2'h3;

   // Communication state codes
   localparam logic [WORD_W-1:0] CS_SETUP = 16'h0000;
   localparam logic [WORD_W-1:0] CS_INIT = 16'h0001;
   localparam logic [WORD_W-1:0] CS_WAIT_COMM = 16'h0002;
   localparam logic [WORD_W-1:0] CS_IDLE = 16'h0003;
   localparam logic [WORD_W-1:0] CS_DATA_ACTIVE = 16'h0004;
   localparam logic [WORD_W-1:0] CS_ERROR = 16'h0005;
   localparam logic [WORD_W-1:0] CS_EXCEPTION = 16'h0007;
   localparam logic [WORD_W-1:0] CS_ACCESS_ERROR = 16'h0008;

   typedef enum logic [2:0] {
      ST_SETUP, ST_INIT, ST_WAIT_COMM, ST_IDLE, ST_DATA_ACTIVE,
      ST_ERROR, ST_EXCEPTION, ST_ACCESS_ERROR
   } comm_state_t;

   // Drive conditions seen by the status word
   typedef struct packed {
      logic can_enable;
      logic enabled;
      logic fault;
      logic coast_stop;
      logic quick_stop;
      logic alarm;
      logic remote;
   } drive_cond_t;

   // Events reported by the network interface
   typedef struct packed {
      logic present;
      logic [TYPE_W-1:0] kind;
      logic cfg_received;
      logic init_done;
      logic master_conn;
      logic master_run;
      logic comm_err;
      logic iface_fault;
      logic link_fault;
      logic reinit;
   } net_event_t;
endpackage
`default_nettype wire

// *** src/status_word_build.sv ***
// Purpose: Assembles the drive status word each cycle
// Assumes: Conditions are synchronous levels
// Notes: Output is registered, reserved bits held at zero
`default_nettype none
module status_word_build (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire drive_status_pkg::drive_cond_t cond_in,
   input wire logic cmd_permits_in,
   output logic [drive_status_pkg::WORD_W-1:0] word_out
);
   import drive_status_pkg::*;

   logic [WORD_W-1:0] word_nxt;

   // One condition per bit, all others zero
   always_comb begin
      word_nxt = WORD_ZERO;
      word_nxt[SW_READY_ON] = cond_in.can_enable;
      word_nxt[SW_READY_OP] = cmd_permits_in;
      word_nxt[SW_OP_EN] = cond_in.enabled;
      word_nxt[SW_FAULT] = cond_in.fault;
      word_nxt[SW_NO_COAST] = ~cond_in.coast_stop;
      word_nxt[SW_NO_QSTOP] = ~cond_in.quick_stop;
      word_nxt[SW_ON_INHIBIT] = 1'b0;
      word_nxt[SW_WARNING] = cond_in.alarm;
      word_nxt[SW_REMOTE] = cond_in.remote;
   end

   // Registered word, zero from reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         word_out <= STATUS_RESET;
      end else begin
         word_out <= word_nxt;
      end
   end
endmodule
`default_nettype wire

// *** src/comm_state_track.sv ***
// Purpose: Tracks the network interface communication state
// Assumes: Event inputs are synchronous levels
// Notes: Fault states hold until a reinit request or until no module is identified
`default_nettype none
module comm_state_track (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire drive_status_pkg::net_event_t ev_in,
   output logic [drive_status_pkg::WORD_W-1:0] code_out,
   output logic [drive_status_pkg::TYPE_W-1:0] kind_out
);
   import drive_status_pkg::*;

   comm_state_t state_r;
   comm_state_t state_nxt;
   logic [WORD_W-1:0] code_nxt;
   logic identified;

   assign identified = ev_in.present && (ev_in.kind != MOD_NONE);

   // Next state, faults ahead of errors ahead of progress
   always_comb begin
      state_nxt = state_r;
      if (!identified) begin
         state_nxt = ST_SETUP;
      end else if (state_r == ST_EXCEPTION ||
                   state_r == ST_ACCESS_ERROR) begin
         if (ev_in.reinit) begin
            state_nxt = ST_SETUP;
         end
      end else if (ev_in.link_fault) begin
         state_nxt = ST_ACCESS_ERROR;
      end else if (ev_in.iface_fault) begin
         state_nxt = ST_EXCEPTION;
      end else if (ev_in.reinit) begin
         state_nxt = ST_SETUP;
      end else if (ev_in.comm_err) begin
         state_nxt = ST_ERROR;
      end else begin
         unique case (state_r)
            ST_SETUP: begin
               if (ev_in.cfg_received) begin
                  state_nxt = ST_INIT;
               end
            end
            ST_INIT: begin
               if (ev_in.init_done) begin
                  state_nxt = ST_WAIT_COMM;
               end
            end
            ST_WAIT_COMM, ST_IDLE, ST_DATA_ACTIVE, ST_ERROR: begin
               if (!ev_in.master_conn) begin
                  state_nxt = ST_WAIT_COMM;
               end else if (ev_in.master_run) begin
                  state_nxt = ST_DATA_ACTIVE;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
            ST_EXCEPTION, ST_ACCESS_ERROR: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // Code for each state; code six has no state
   always_comb begin
      unique case (state_nxt)
         ST_SETUP: code_nxt = CS_SETUP;
         ST_INIT: code_nxt = CS_INIT;
         ST_WAIT_COMM: code_nxt = CS_WAIT_COMM;
         ST_IDLE: code_nxt = CS_IDLE;
         ST_DATA_ACTIVE: code_nxt = CS_DATA_ACTIVE;
         ST_ERROR: code_nxt = CS_ERROR;
         ST_EXCEPTION: code_nxt = CS_EXCEPTION;
         ST_ACCESS_ERROR: code_nxt = CS_ACCESS_ERROR;
      endcase
   end

   // State and reported code
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= ST_SETUP;
         code_out <= CS_SETUP;
      end else begin
         state_r <= state_nxt;
         code_out <= code_nxt;
      end
   end

   // Module type, zero when absent or unknown
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         kind_out <= MOD_NONE;
      end else if (ev_in.present) begin
         kind_out <= ev_in.kind;
      end else begin
         kind_out <= MOD_NONE;
      end
   end
endmodule
`default_nettype wire

// *** src/drive_fieldbus_status_report.sv ***
// Purpose: Drive status report toward a network master
// Assumes: All inputs synchronous to clk_in
// Notes: Parameter port answers one cycle after a request
`default_nettype none
module drive_fieldbus_status_report (
   input wire logic clk_in,
   input wire logic rst_in,
   // Drive conditions and profile selection
   input wire drive_status_pkg::drive_cond_t cond_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] data_profile_select_in,
   // Network interface events
   input wire drive_status_pkg::net_event_t net_in,
   // Cyclic fieldbus exchange
   input wire logic fb_cycle_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] fb_command_in,
   output logic [drive_status_pkg::WORD_W-1:0] fb_status_out,
   output logic fb_status_valid_out,
   // Parameter access port
   input wire logic param_req_in,
   input wire logic param_wr_in,
   input wire logic param_from_fb_in,
   input wire logic [drive_status_pkg::PNUM_W-1:0] param_num_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] param_wdata_in,
   output logic param_ack_out,
   output logic param_err_out,
   output logic [drive_status_pkg::WORD_W-1:0] param_rdata_out,
   // Decoded command outputs
   output logic [drive_status_pkg::WORD_W-1:0] drive_command_word_out,
   output logic run_permit_out,
   output logic setpoint_enable_out,
   output logic fault_ack_out
);
   import drive_status_pkg::*;

   logic [WORD_W-1:0] drive_command_word_r;
   logic [WORD_W-1:0] drive_command_word_nxt;
   logic [WORD_W-1:0] drive_status_word;
   logic [WORD_W-1:0] network_comm_state;
   logic [TYPE_W-1:0] network_module_type;
   logic drive_profile;
   logic cmd_permits;
   logic cyc_write;
   logic param_write_ok;
   logic param_mapped;
   logic [WORD_W-1:0] param_rdata_nxt;
   logic param_err_nxt;
   logic fault_ack_prev_r;

   // Profile selection governs status and command use
   assign drive_profile = (data_profile_select_in == PROFILE_DRIVE);

   // Cyclic command write from the master
   assign cyc_write = fb_cycle_in && drive_profile;

   // Acyclic command write, fieldbus source only
   assign param_write_ok = param_req_in && param_wr_in &&
                           param_from_fb_in && drive_profile &&
                           (param_num_in == PNUM_COMMAND_WORD);

   // Command word next value, cyclic path first
   always_comb begin
      drive_command_word_nxt = drive_command_word_r;
      if (cyc_write) begin
         drive_command_word_nxt = fb_command_in;
      end else if (param_write_ok) begin
         drive_command_word_nxt = param_wdata_in;
      end
   end

   // Command word storage
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         drive_command_word_r <= COMMAND_RESET;
      end else begin
         drive_command_word_r <= drive_command_word_nxt;
      end
   end

   // Commands most recently received permit operation
   assign cmd_permits = drive_command_word_r[CW_ON] &&
                        drive_command_word_r[CW_NO_COAST] &&
                        drive_command_word_r[CW_NO_QSTOP] &&
                        drive_command_word_r[CW_EN_OP];

   // Status word assembly
   status_word_build u_status (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cond_in(cond_in),
      .cmd_permits_in(cmd_permits),
      .word_out(drive_status_word)
   );

   // Network module type and communication state
   comm_state_track u_comm (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ev_in(net_in),
      .code_out(network_comm_state),
      .kind_out(network_module_type)
   );

   // Status word to the fieldbus only under drive profile
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fb_status_out <= STATUS_RESET;
         fb_status_valid_out <= 1'b0;
      end else if (drive_profile) begin
         fb_status_out <= drive_status_word;
         fb_status_valid_out <= 1'b1;
      end else begin
         fb_status_out <= WORD_ZERO;
         fb_status_valid_out <= 1'b0;
      end
   end

   // Parameter number decode
   always_comb begin
      param_mapped = 1'b1;
      param_rdata_nxt = WORD_ZERO;
      unique case (param_num_in)
         PNUM_STATUS_WORD: param_rdata_nxt = drive_status_word;
         PNUM_COMMAND_WORD: param_rdata_nxt = drive_command_word_r;
         PNUM_MODULE_TYPE: begin
            param_rdata_nxt = {{(WORD_W-TYPE_W){1'b0}},
                               network_module_type};
         end
         PNUM_COMM_STATE: param_rdata_nxt = network_comm_state;
         PNUM_PROFILE_SEL: param_rdata_nxt = data_profile_select_in;
         default: param_mapped = 1'b0;
      endcase
   end

   // Unmapped numbers and refused writes report an error
   always_comb begin
      param_err_nxt = 1'b0;
      if (!param_mapped) begin
         param_err_nxt = 1'b1;
      end else if (param_wr_in && !param_write_ok) begin
         param_err_nxt = 1'b1;
      end
   end

   // Parameter answer one cycle after the request
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         param_ack_out <= 1'b0;
         param_err_out <= 1'b0;
         param_rdata_out <= WORD_ZERO;
      end else if (param_req_in) begin
         param_ack_out <= 1'b1;
         param_err_out <= param_err_nxt;
         param_rdata_out <= param_wr_in ? WORD_ZERO : param_rdata_nxt;
      end else begin
         param_ack_out <= 1'b0;
         param_err_out <= 1'b0;
         param_rdata_out <= WORD_ZERO;
      end
   end

   // Decoded command levels toward the drive
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         drive_command_word_out <= COMMAND_RESET;
         run_permit_out <= 1'b0;
         setpoint_enable_out <= 1'b0;
      end else begin
         drive_command_word_out <= drive_command_word_r;
         run_permit_out <= cmd_permits;
         setpoint_enable_out <= drive_command_word_r[CW_EN_SETPOINT];
      end
   end

   // Fault acknowledge pulse on the rising command bit while a fault stands
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fault_ack_prev_r <= 1'b0;
         fault_ack_out <= 1'b0;
      end else begin
         fault_ack_prev_r <= drive_command_word_r[CW_FAULT_ACK];
         fault_ack_out <= drive_command_word_r[CW_FAULT_ACK] &&
                          !fault_ack_prev_r && cond_in.fault;
      end
   end
endmodule
`default_nettype wire

// *** tb/status_report_chk.sv ***
// Purpose: Port checks for the drive status report block
// Assumes: One clock, asynchronous active high reset
// Notes: Bound to the top module at the foot of this file
`default_nettype none
module status_report_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire drive_status_pkg::drive_cond_t cond_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] data_profile_select_in,
   input wire logic fb_cycle_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] fb_command_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] fb_status_out,
   input wire logic fb_status_valid_out,
   input wire logic param_req_in,
   input wire logic param_wr_in,
   input wire logic param_from_fb_in,
   input wire logic [drive_status_pkg::PNUM_W-1:0] param_num_in,
   input wire logic param_ack_out,
   input wire logic param_err_out,
   input wire logic [drive_status_pkg::WORD_W-1:0] param_rdata_out,
   input wire logic [drive_status_pkg::WORD_W-1:0] drive_command_word_out,
   input wire logic run_permit_out,
   input wire drive_status_pkg::net_event_t net_in
);
   import drive_status_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Status bit follows its condition two edges on
   property p_bit(int b, logic v);
      (data_profile_select_in == PROFILE_DRIVE)[*2] |=>
         fb_status_out[b] == $past(v, 2);
   endproperty
   AST_FAULT_BIT: assert property (p_bit(SW_FAULT, cond_in.fault))
      else $error("fault bit wrong");
   AST_COAST_BIT: assert property (p_bit(4, !cond_in.coast_stop))
      else $error("coast bit wrong");
   AST_QSTOP_BIT: assert property (p_bit(5, !cond_in.quick_stop))
      else $error("quick stop bit wrong");
   AST_REMOTE_BIT: assert property (p_bit(9, cond_in.remote))
      else $error("remote bit wrong");
   AST_RESERVED: assert property (fb_status_out[15:10] == 6'h00 &&
      !fb_status_out[8] && !fb_status_out[6]) else $error("reserved set");
   AST_PROFILE_OFF: assert property (data_profile_select_in !=
      PROFILE_DRIVE |=> fb_status_out == WORD_ZERO && !fb_status_valid_out)
      else $error("status sent outside drive profile");
   AST_PROFILE_ON: assert property (data_profile_select_in ==
      PROFILE_DRIVE |=> fb_status_valid_out) else $error("valid missing");
   AST_ACK: assert property (param_req_in |=> param_ack_out)
      else $error("ack missing");
   AST_NO_ACK: assert property (!param_req_in |=> !param_ack_out)
      else $error("stray ack");
   AST_STATUS_RO: assert property (param_req_in && param_wr_in &&
      param_num_in == PNUM_STATUS_WORD |=> param_err_out)
      else $error("status word written");
   AST_FB_ONLY: assert property (param_req_in && param_wr_in &&
      !param_from_fb_in |=> param_err_out) else $error("local write taken");
   AST_CMD_PATH: assert property (fb_cycle_in && data_profile_select_in
      == PROFILE_DRIVE |-> ##2 drive_command_word_out ==
      $past(fb_command_in, 2) && run_permit_out ==
      &$past(fb_command_in[3:0], 2)) else $error("command path wrong");
   AST_CODE_RANGE: assert property (param_ack_out && !param_err_out &&
      $past(param_num_in) == PNUM_COMM_STATE |-> param_rdata_out <= 16'h0008
      && param_rdata_out != 16'h0006) else $error("bad comm code");
   AST_TYPE_RANGE: assert property (param_ack_out && !param_err_out &&
      $past(param_num_in) == PNUM_MODULE_TYPE |-> param_rdata_out <= 16'h0003
      && param_rdata_out[1:0] ==
      $past(net_in.present ? net_in.kind : MOD_NONE, 2))
      else $error("bad module type");
   cover property (param_ack_out && param_err_out);
   cover property ($fell(fb_status_valid_out));
   cover property ($rose(run_permit_out));
endmodule
bind drive_fieldbus_status_report status_report_chk u_chk (.clk_in, .rst_in,
   .cond_in, .data_profile_select_in, .fb_cycle_in, .fb_command_in,
   .fb_status_out, .fb_status_valid_out, .param_req_in, .param_wr_in,
   .param_from_fb_in, .param_num_in, .param_ack_out, .param_err_out,
   .param_rdata_out, .drive_command_word_out, .run_permit_out, .net_in);
`default_nettype wire

// *** tb/net_master_model.sv ***
// Purpose: Network master model for cyclic and parameter traffic
// Assumes: Requests launched at falling edges
// Notes: Released command, number and write data lines show the inverse of their last value
`default_nettype none
module net_master_model (
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic err_in,
   input wire logic [drive_status_pkg::WORD_W-1:0] rdata_in,
   output logic cycle_out,
   output logic [drive_status_pkg::WORD_W-1:0] cmd_out,
   output logic req_out,
   output logic wr_out,
   output logic from_fb_out,
   output logic [drive_status_pkg::PNUM_W-1:0] num_out,
   output logic [drive_status_pkg::WORD_W-1:0] wdata_out
);
   import drive_status_pkg::*;
   initial begin
      {cycle_out, cmd_out, req_out, wr_out, from_fb_out} = '0;
      {num_out, wdata_out} = '0;
   end
   // One cyclic command, then the data line flips
   task automatic cyc(input logic [WORD_W-1:0] c);
      @(negedge clk_in);
      cycle_out = 1'b1;
      cmd_out = c;
      @(negedge clk_in);
      cycle_out = 1'b0;
      cmd_out = ~c;
   endtask
   // One parameter request, answer taken with the ack
   task automatic access(input logic w, f, input logic [PNUM_W-1:0] n,
      input logic [WORD_W-1:0] d, output logic [WORD_W-1:0] rd,
      output logic er, ak);
      @(negedge clk_in);
      req_out = 1'b1;
      wr_out = w;
      from_fb_out = f;
      num_out = n;
      wdata_out = d;
      @(negedge clk_in);
      rd = rdata_in;
      er = err_in;
      ak = ack_in;
      req_out = 1'b0;
      num_out = ~n;
      wdata_out = ~d;
   endtask
endmodule
`default_nettype wire

// *** tb/test_drive_fieldbus_status_report.sv ***
// Purpose: Self-checking bench for the drive status report block
// Assumes: Inputs change at falling edges
// Notes: Parameter traffic goes through the master model
`default_nettype none
module test_drive_fieldbus_status_report;
   timeunit 1ns;
   timeprecision 1ps;
   import drive_status_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   drive_cond_t cond = '0;
   net_event_t net = '0;
   logic [15:0] profile = PROFILE_DRIVE;
   logic fb_cycle, req, wr, from_fb, ack, err, permit, spen, valid, fack;
   logic [15:0] fb_cmd, num, wdata, rdata, status, cmd_out;
   int num_errors = 0;
   int samples_checked = 0;
   always #2.5 clk = ~clk;
   drive_fieldbus_status_report dut (.clk_in(clk), .rst_in(rst),
      .cond_in(cond), .data_profile_select_in(profile), .net_in(net),
      .fb_cycle_in(fb_cycle), .fb_command_in(fb_cmd), .fb_status_out(status),
      .fb_status_valid_out(valid), .param_req_in(req), .param_wr_in(wr),
      .param_from_fb_in(from_fb), .param_num_in(num), .param_wdata_in(wdata),
      .param_ack_out(ack), .param_err_out(err), .param_rdata_out(rdata),
      .drive_command_word_out(cmd_out), .run_permit_out(permit),
      .setpoint_enable_out(spen), .fault_ack_out(fack));
   net_master_model u_master (.clk_in(clk), .ack_in(ack), .err_in(err),
      .rdata_in(rdata), .cycle_out(fb_cycle), .cmd_out(fb_cmd),
      .req_out(req), .wr_out(wr), .from_fb_out(from_fb), .num_out(num),
      .wdata_out(wdata));
   task chk(input string what, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Expected status word from conditions and command permit
   function automatic logic [15:0] exp_sw(drive_cond_t c, logic p);
      logic [15:0] e;
      e = 16'h0000;
      e[0] = c.can_enable;
      e[1] = p;
      e[2] = c.enabled;
      e[3] = c.fault;
      e[4] = !c.coast_stop;
      e[5] = !c.quick_stop;
      e[7] = c.alarm;
      e[9] = c.remote;
      return e;
   endfunction
   task acc(input logic w, f, input logic [15:0] n, d, e, input logic ee);
      logic [15:0] rd;
      logic er, ak;
      u_master.access(w, f, n, d, rd, er, ak);
      chk("ack", 16'(ak), 16'h0001);
      chk("err", 16'(er), 16'(ee));
      if (!w && !ee) chk("rdata", rd, e);
   endtask
   task t_bits;
      for (int i = 0; i < 7; i++) begin
         cond = drive_cond_t'(7'h01 << i);
         repeat (4) @(negedge clk);
         chk("status", status, exp_sw(cond, 1'b0));
         acc(0, 0, PNUM_STATUS_WORD, 0, exp_sw(cond, 1'b0), 0);
      end
      cond = '0;
      $display("bits test done");
   endtask
   task t_cmd;
      u_master.cyc(16'h000F);
      repeat (3) @(negedge clk);
      chk("permit", 16'(permit), 16'h0001);
      chk("command", cmd_out, 16'h000F);
      chk("status", status, exp_sw(cond, 1'b1));
      acc(1, 0, PNUM_COMMAND_WORD, 16'h0040, 0, 1);
      acc(1, 1, PNUM_STATUS_WORD, 16'h0040, 0, 1);
      acc(0, 0, 16'h0001, 0, 0, 1);
      acc(0, 0, PNUM_PROFILE_SEL, 0, PROFILE_DRIVE, 0);
      acc(1, 1, PNUM_COMMAND_WORD, 16'h0040, 0, 0);
      repeat (3) @(negedge clk);
      chk("command", cmd_out, 16'h0040);
      chk("setpoint", 16'(spen), 16'h0001);
      chk("status", status, exp_sw(cond, 1'b0));
      $display("command test done");
   endtask
   task t_profile;
      profile = 16'h0002;
      u_master.cyc(16'h000F);
      repeat (3) @(negedge clk);
      chk("status", status, WORD_ZERO);
      chk("valid", 16'(valid), 16'h0000);
      chk("command", cmd_out, 16'h0040);
      profile = PROFILE_DRIVE;
      repeat (3) @(negedge clk);
      chk("valid", 16'(valid), 16'h0001);
      $display("profile test done");
   endtask
   // Fault acknowledge pulses once, only while a fault stands
   task t_fault;
      cond.fault = 1'b1;
      u_master.cyc(16'h0080);
      @(negedge clk);
      chk("fault ack", 16'(fack), 16'h0001);
      @(negedge clk);
      chk("fault ack", 16'(fack), 16'h0000);
      u_master.cyc(16'h0000);
      cond.fault = 1'b0;
      u_master.cyc(16'h0080);
      @(negedge clk);
      chk("fault ack", 16'(fack), 16'h0000);
      $display("fault ack test done");
   endtask
   task t_type;
      for (int k = 0; k < 4; k++) begin
         net.present = 1'b1;
         net.kind = k[1:0];
         repeat (2) @(negedge clk);
         acc(0, 0, PNUM_MODULE_TYPE, 0, 16'(k), 0);
      end
      net.present = 1'b0;
      repeat (2) @(negedge clk);
      acc(0, 0, PNUM_MODULE_TYPE, 0, 16'h0000, 0);
      $display("type test done");
   endtask
   task step(input logic [15:0] e);
      repeat (4) @(negedge clk);
      acc(0, 0, PNUM_COMM_STATE, 0, e, 0);
   endtask
   task t_comm;
      net = '0;
      net.present = 1'b1;
      net.kind = MOD_MODBUS_TCP;
      step(CS_SETUP);
      net.cfg_received = 1'b1;
      step(CS_INIT);
      net.init_done = 1'b1;
      step(CS_WAIT_COMM);
      net.master_conn = 1'b1;
      step(CS_IDLE);
      net.master_run = 1'b1;
      step(CS_DATA_ACTIVE);
      net.comm_err = 1'b1;
      step(CS_ERROR);
      net.comm_err = 1'b0;
      step(CS_DATA_ACTIVE);
      net.iface_fault = 1'b1;
      step(CS_EXCEPTION);
      net.iface_fault = 1'b0;
      step(CS_EXCEPTION);
      net.reinit = 1'b1;
      net.cfg_received = 1'b0;
      step(CS_SETUP);
      net.reinit = 1'b0;
      net.cfg_received = 1'b1;
      step(CS_DATA_ACTIVE);
      net.link_fault = 1'b1;
      net.iface_fault = 1'b1;
      step(CS_ACCESS_ERROR);
      $display("comm state test done");
   endtask
   // Cuts a hang short
   initial begin
      #20000;
      num_errors++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk("reset status", status, STATUS_RESET);
      rst = 1'b0;
      t_bits();
      t_cmd();
      t_profile();
      t_fault();
      t_type();
      t_comm();
      print_verdict();
   end
endmodule
`default_nettype wire
